/* File: core/rib_pkg_mem.sv */
// Shared constants and types for the remote input buffer, plus its byte store

//----------------------------------------
// Package
//----------------------------------------
package rib_pkg;
	localparam int unsigned IB_DEPTH = 350;
	localparam int unsigned CNT_W = 9;
	localparam int unsigned XOFF_PCT = 80;
	localparam int unsigned XON_PCT = 40;
	localparam int unsigned PCT_FULL = 100;
	localparam logic [7:0] XOFF_CHAR = 8'h13;
	localparam logic [7:0] XON_CHAR = 8'h11;
	localparam logic [7:0] OPC_REPLY = 8'h31;
	localparam logic [7:0] EOI_FILL = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;

	// Serial flow-control selection
	typedef enum logic [1:0] {
		RIB_FLOW_NONE = 2'b00,
		RIB_FLOW_SOFT = 2'b01,
		RIB_FLOW_RTS = 2'b10
	} rib_flow_t;

	// One stored entry: a data byte or an end marker
	typedef struct packed {
		logic eoi;
		logic [7:0] data;
	} rib_entry_t;

	// Byte offered by a source port
	typedef struct packed {
		logic valid;
		logic eoi;
		logic [7:0] data;
	} rib_in_t;
endpackage

`timescale 1ns/1ps

//----------------------------------------
// Byte store with registered read data
//----------------------------------------
module rib_mem
	import rib_pkg::*;
#(
	parameter int unsigned DEPTH = IB_DEPTH,
	parameter int unsigned AW = CNT_W
) (
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire rib_entry_t wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output rib_entry_t rd_data
);
	rib_entry_t mem [DEPTH];

	// No reset on the array; the counters guard against stale reads
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* File: core/rib_top.sv */
// Remote input buffer with bus hold-off, serial flow control and completion sync
`timescale 1ns/1ps

module rib_top
	import rib_pkg::*;
#(
	parameter int unsigned DEPTH = IB_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic port_sel,
	input wire rib_flow_t flow_mode,
	input wire rib_in_t par_in,
	output logic par_nrfd,
	input wire rib_in_t ser_in,
	input wire logic dev_clear,
	input wire logic rd_ready,
	output logic rd_valid,
	output rib_entry_t rd_entry,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic rts,
	input wire logic ops_busy,
	input wire logic cmd_opc,
	input wire logic cmd_opc_query,
	input wire logic cmd_wai,
	input wire logic status_clear,
	output logic esr_opc,
	input wire logic oq_ready,
	output logic oq_valid,
	output logic [7:0] oq_data,
	output logic wait_hold
);
	localparam logic [CNT_W-1:0] FULL_LVL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] HI_LVL = CNT_W'(DEPTH * XOFF_PCT / PCT_FULL);
	localparam logic [CNT_W-1:0] LO_LVL = CNT_W'(DEPTH * XON_PCT / PCT_FULL);

	//----------------------------------------
	// Buffer state
	//----------------------------------------
	logic [CNT_W-1:0] cnt_q, cnt_d, wp_q, wp_d, rp_q, rp_d;
	logic nrfd_q, nrfd_d, eoi_pend_q, eoi_pend_d, fetch_q, fetch_d;
	logic out_v_q, out_v_d, rd_valid_q, rd_valid_d;
	rib_entry_t out_q, out_d, wr_entry, mem_rd;
	logic par_take, ser_take, eoi_wr, wr_en, pop, take;

	// Flow control and completion state
	logic off_q, off_d, tx_valid_q, tx_valid_d, rts_q, rts_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic opc_arm_q, opc_arm_d, esr_q, esr_d, oq_arm_q, oq_arm_d;
	logic oq_valid_q, oq_valid_d, wait_q, wait_d;

	rib_mem #(.DEPTH(DEPTH), .AW(CNT_W)) u_mem (
		.ref_clk(ref_clk),
		.wr_en(wr_en),
		.wr_addr(wp_q),
		.wr_data(wr_entry),
		.rd_en(pop),
		.rd_addr(rp_q),
		.rd_data(mem_rd)
	);

	//----------------------------------------
	// Store write, read and occupancy
	//----------------------------------------
	// Source selection and entry building
	always_comb begin
		take = rd_valid_q && rd_ready;
		par_take = !port_sel && par_in.valid && !nrfd_q && !dev_clear;
		// Serial has no hold-off; a byte arriving full is lost
		ser_take = port_sel && ser_in.valid && !eoi_pend_q && (cnt_q < FULL_LVL) && !dev_clear;
		// end marker written as its own entry
		eoi_wr = eoi_pend_q && (cnt_q < FULL_LVL) && !dev_clear;
		wr_en = par_take || ser_take || eoi_wr;
		wr_entry.eoi = eoi_wr;
		wr_entry.data = eoi_wr ? EOI_FILL : (par_take ? par_in.data : ser_in.data);
		// oldest entry fetched once the output slot frees
		pop = (cnt_q != CNT_ZERO) && !fetch_q && (!out_v_q || take) && !dev_clear;
	end

	// Next values for pointers, count and delivery slot
	always_comb begin
		cnt_d = cnt_q + (wr_en ? CNT_ONE : CNT_ZERO) - (pop ? CNT_ONE : CNT_ZERO);
		wp_d = wr_en ? ((wp_q == LAST_IDX) ? CNT_ZERO : wp_q + CNT_ONE) : wp_q;
		rp_d = pop ? ((rp_q == LAST_IDX) ? CNT_ZERO : rp_q + CNT_ONE) : rp_q;
		eoi_pend_d = (eoi_pend_q && !eoi_wr) || (par_take && par_in.eoi);
		fetch_d = pop;
		out_v_d = fetch_q ? 1'b1 : (out_v_q && !take);
		out_d = fetch_q ? mem_rd : out_q;
		// hold off while full or a marker still waits
		// one pop from full drops the hold for one byte
		nrfd_d = (cnt_d >= FULL_LVL) || eoi_pend_d;
		if (dev_clear) begin
			cnt_d = CNT_ZERO;
			wp_d = CNT_ZERO;
			rp_d = CNT_ZERO;
			eoi_pend_d = 1'b0;
			fetch_d = 1'b0;
			out_v_d = 1'b0;
			nrfd_d = 1'b0;
		end
	end

	// power-up reset also empties the store
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_q <= CNT_ZERO;
			wp_q <= CNT_ZERO;
			rp_q <= CNT_ZERO;
			eoi_pend_q <= 1'b0;
			fetch_q <= 1'b0;
			out_v_q <= 1'b0;
			out_q <= '0;
			nrfd_q <= 1'b0;
			rd_valid_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			eoi_pend_q <= eoi_pend_d;
			fetch_q <= fetch_d;
			out_v_q <= out_v_d;
			out_q <= out_d;
			nrfd_q <= nrfd_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	//----------------------------------------
	// Serial flow control
	//----------------------------------------
	// Hysteresis keeps the host from chattering near a single level
	always_comb begin
		off_d = off_q;
		tx_valid_d = tx_valid_q && !tx_ready;
		tx_data_d = tx_data_q;
		if (!tx_valid_d) begin
			// stop character at the upper level
			if (flow_mode != RIB_FLOW_NONE && !off_q && cnt_q >= HI_LVL) begin
				off_d = 1'b1;
				tx_valid_d = (flow_mode == RIB_FLOW_SOFT);
				tx_data_d = XOFF_CHAR;
			// resume character below the lower level
			end else if (off_q && cnt_q < LO_LVL) begin
				off_d = 1'b0;
				tx_valid_d = (flow_mode == RIB_FLOW_SOFT);
				tx_data_d = XON_CHAR;
			end
		end
		rts_d = !(off_d && flow_mode == RIB_FLOW_RTS);
		if (dev_clear) begin
			off_d = 1'b0;
			tx_valid_d = 1'b0;
			rts_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			off_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_data_q <= XON_CHAR;
			rts_q <= 1'b1;
		end else begin
			off_q <= off_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
			rts_q <= rts_d;
		end
	end

	//----------------------------------------
	// Completion synchronisation
	//----------------------------------------
	// Arms wait for the busy input to fall; status clear cancels them
	always_comb begin
		// bit set when work finishes; set beats clear
		opc_arm_d = (opc_arm_q && ops_busy && !status_clear) || cmd_opc;
		esr_d = (esr_q && !status_clear) || (opc_arm_q && !ops_busy);
		// reply posted only once work has finished
		oq_valid_d = (oq_valid_q && !oq_ready) || (oq_arm_q && !ops_busy);
		oq_arm_d = (oq_arm_q && (ops_busy || oq_valid_q) && !status_clear) || cmd_opc_query;
		// hold delivery of every byte, even one already offered, while waiting
		wait_d = (wait_q && ops_busy) || cmd_wai;
		rd_valid_d = out_v_d && !wait_d;
		if (oq_valid_q && !oq_ready) begin
			oq_valid_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			opc_arm_q <= 1'b0;
			esr_q <= 1'b0;
			oq_arm_q <= 1'b0;
			oq_valid_q <= 1'b0;
			wait_q <= 1'b0;
		end else begin
			opc_arm_q <= opc_arm_d;
			esr_q <= esr_d;
			oq_arm_q <= oq_arm_d;
			oq_valid_q <= oq_valid_d;
			wait_q <= wait_d;
		end
	end

	// Outputs straight from flip-flops except the constant reply byte
	assign par_nrfd = nrfd_q;
	assign rd_valid = rd_valid_q;
	assign rd_entry = out_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign rts = rts_q;
	assign esr_opc = esr_q;
	assign oq_valid = oq_valid_q;
	assign oq_data = OPC_REPLY;
	assign wait_hold = wait_q;

	//----------------------------------------
	// Assertions
	//----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_pop_full;
		cnt_q == FULL_LVL && pop && !eoi_pend_q && !dev_clear;
	endsequence

	sequence s_waiting;
		wait_q && ops_busy && !cmd_wai;
	endsequence

	a_full_holds_nrfd: assert property (cnt_q == FULL_LVL |-> nrfd_q && !par_take)
		else $error("byte accepted or ready shown while full");
	a_one_after_pop: assert property (s_pop_full |=> !nrfd_q and (par_take |=> nrfd_q))
		else $error("handshake not freed for exactly one byte");
	a_eoi_own_entry: assert property (par_take && par_in.eoi |=> eoi_pend_q && nrfd_q)
		else $error("end marker not queued as own entry");
	a_count_tracks: assert property (!dev_clear |=> cnt_q == $past(cnt_q)
		+ ($past(wr_en) ? CNT_ONE : CNT_ZERO) - ($past(pop) ? CNT_ONE : CNT_ZERO))
		else $error("occupancy count wrong");
	a_clear_flow_on: assert property (dev_clear |=> cnt_q == CNT_ZERO && !nrfd_q && rts_q
		&& !rd_valid_q && !off_q)
		else $error("clear did not restore flow-on state");
	a_xoff_at_high: assert property (flow_mode == RIB_FLOW_SOFT && !off_q && !tx_valid_q
		&& cnt_q >= HI_LVL && !dev_clear |=> tx_valid_q && tx_data_q == XOFF_CHAR)
		else $error("stop character not sent at upper level");
	a_xon_at_low: assert property (flow_mode == RIB_FLOW_SOFT && off_q && !tx_valid_q
		&& cnt_q < LO_LVL && !dev_clear |=> tx_valid_q && tx_data_q == XON_CHAR)
		else $error("resume character not sent below lower level");
	a_rts_levels: assert property (flow_mode == RIB_FLOW_RTS && cnt_q >= HI_LVL && !dev_clear
		##1 flow_mode == RIB_FLOW_RTS |-> !rts_q)
		else $error("request-to-send still high at upper level");
	a_opc_sets_bit: assert property (opc_arm_q && !ops_busy |=> esr_opc)
		else $error("completion bit not set");
	a_reply_after_done: assert property ($rose(oq_valid_q) |-> !$past(ops_busy)
		&& oq_data == OPC_REPLY)
		else $error("reply posted while work pending");
	a_wait_blocks: assert property (s_waiting |=> !rd_valid_q && wait_hold)
		else $error("byte delivered during wait");
endmodule

/* File: testbench/remote_input_buffer_flow_control_bench.sv */
// Self-checking bench for the remote input buffer
`timescale 1ns/1ps

module remote_input_buffer_flow_control_bench;
	import rib_pkg::*;
	typedef struct packed {
		logic [1:0] kind;
		logic [3:0] busy;
		logic esr;
		logic oq;
	} rib_row_t;
	logic ref_clk, rst, port_sel, dev_clear, rd_ready, tx_ready, ops_busy;
	logic cmd_opc, cmd_opc_query, cmd_wai, status_clear, oq_ready;
	logic par_nrfd, rd_valid, tx_valid, rts, esr_opc, oq_valid, wait_hold;
	rib_flow_t flow_mode;
	rib_in_t par_in, ser_in;
	rib_entry_t rd_entry, e;
	logic [7:0] tx_data, oq_data;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int xon_count = 0;
	// Kind 0 set-bit, 1 query, 2 wait, 3 set-bit cancelled by status clear
	rib_row_t rows [0:6] = '{'{2'h0, 4'h0, 1'b1, 1'b0}, '{2'h0, 4'h5, 1'b1, 1'b0},
		'{2'h1, 4'h0, 1'b0, 1'b1}, '{2'h1, 4'h5, 1'b0, 1'b1}, '{2'h2, 4'h0, 1'b0, 1'b0},
		'{2'h2, 4'h5, 1'b0, 1'b0}, '{2'h3, 4'h5, 1'b0, 1'b0}};

	rib_top dut_u (.ref_clk, .rst, .port_sel, .flow_mode, .par_in, .par_nrfd, .ser_in,
		.dev_clear, .rd_ready, .rd_valid, .rd_entry, .tx_ready, .tx_valid, .tx_data, .rts,
		.ops_busy, .cmd_opc, .cmd_opc_query, .cmd_wai, .status_clear, .esr_opc, .oq_ready,
		.oq_valid, .oq_data, .wait_hold);
	rib_host_model host_u (.ref_clk, .par_nrfd, .par_in, .ser_in);

	//----------------------------------------
	// Clock, timeout and flow-on monitor
	//----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		// Only this process writes the count; tasks compare against a snapshot
		if (tx_valid && tx_ready && tx_data === XON_CHAR) xon_count <= xon_count + 1;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	//----------------------------------------
	// Helpers
	//----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_val({8'h00, got}, {8'h00, exp});
	endtask
	// Bounded wait, then one-cycle take
	task automatic rd_take(output rib_entry_t x);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		x = rd_entry;
		rd_ready = 1'b1;
		tick(1);
		rd_ready = 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Fill past the upper level, stall when full, drain below the lower level
	task automatic fill_drain(input rib_flow_t m);
		int xon_start;
		flow_mode = m;
		port_sel = 1'b1;
		tx_ready = 1'b0;
		xon_start = xon_count;
		for (int i = 0; i < 281; i++) begin
			host_u.ser_send(i[7:0]);
			if (i >= 279) begin
				tick(3);
				chk_flag(tx_valid, i == 280 && m == RIB_FLOW_SOFT);
				chk_flag(rts, i < 280 || m != RIB_FLOW_RTS);
			end
		end
		if (m == RIB_FLOW_SOFT) chk_val({1'b0, tx_data}, {1'b0, XOFF_CHAR});
		tx_ready = 1'b1;
		port_sel = 1'b0;
		for (int i = 281; i < 351; i++) host_u.par_send(i[7:0], 1'b0);
		tick(1);
		chk_flag(par_nrfd, 1'b1);
		fork
			host_u.par_send(8'h5F, 1'b0);
			begin
				tick(10);
				chk_flag(par_nrfd, 1'b1);
				rd_take(e);
				chk_val(e, 9'h000);
			end
		join
		tick(2);
		chk_flag(par_nrfd, 1'b1);
		for (int i = 1; i < 352; i++) begin
			rd_take(e);
			chk_val(e, {1'b0, i[7:0]});
		end
		tick(4);
		chk_flag(rd_valid, 1'b0);
		chk_flag(xon_count != xon_start, m == RIB_FLOW_SOFT);
		chk_flag(rts, 1'b1);
		$display("fill and drain done, mode %0d", m);
	endtask

	//----------------------------------------
	// Main sequence
	//----------------------------------------
	initial begin
		{rst, port_sel, dev_clear, rd_ready, tx_ready, ops_busy} = 6'h21;
		{cmd_opc, cmd_opc_query, cmd_wai, status_clear, oq_ready} = 5'h00;
		flow_mode = RIB_FLOW_NONE;
		ops_busy = 1'b0;
		tick(3);
		rst = 1'b0;
		tick(1);
		chk_flag(rts, 1'b1);
		chk_flag(par_nrfd | tx_valid | rd_valid, 1'b0);
		chk_flag(esr_opc | oq_valid | wait_hold, 1'b0);
		$display("reset test done");
		foreach (rows[r]) begin
			ops_busy = rows[r].busy != 4'h0;
			cmd_opc = rows[r].kind[0] == rows[r].kind[1];
			cmd_opc_query = rows[r].kind == 2'h1;
			cmd_wai = rows[r].kind == 2'h2;
			tick(1);
			{cmd_opc, cmd_opc_query, cmd_wai} = 3'h0;
			if (rows[r].busy != 4'h0) begin
				tick(rows[r].busy);
				chk_flag(esr_opc | oq_valid, 1'b0);
				chk_flag(wait_hold, rows[r].kind == 2'h2);
				// Clear lands while work is still pending, so it cancels the arm
				status_clear = rows[r].kind == 2'h3;
				tick(1);
				status_clear = 1'b0;
				ops_busy = 1'b0;
				tick(1);
			end
			tick(4);
			chk_flag(esr_opc, rows[r].esr);
			chk_flag(oq_valid, rows[r].oq);
			chk_flag(wait_hold, 1'b0);
			if (rows[r].oq) chk_val({1'b0, oq_data}, {1'b0, OPC_REPLY});
			{status_clear, oq_ready} = 2'h3;
			tick(1);
			{status_clear, oq_ready} = 2'h0;
			tick(1);
			$display("row %0d done", r);
		end
		// Terminator marker follows its byte as its own entry
		host_u.par_send(8'hA5, 1'b1);
		rd_take(e);
		chk_val(e, 9'h0A5);
		rd_take(e);
		chk_val(e, 9'h100);
		$display("end marker test done");
		fill_drain(RIB_FLOW_SOFT);
		fill_drain(RIB_FLOW_RTS);
		// Clear with bytes held and one offered at the output, not taken
		port_sel = 1'b1;
		for (int i = 0; i < 3; i++) host_u.ser_send(8'h40);
		chk_flag(rd_valid, 1'b1);
		// Wait with an entry ready: delivery pauses until work finishes
		ops_busy = 1'b1;
		cmd_wai = 1'b1;
		tick(1);
		cmd_wai = 1'b0;
		tick(2);
		chk_flag(rd_valid, 1'b0);
		ops_busy = 1'b0;
		tick(3);
		chk_flag(rd_valid, 1'b1);
		dev_clear = 1'b1;
		tick(1);
		dev_clear = 1'b0;
		tick(4);
		chk_flag(rd_valid, 1'b0);
		chk_flag(rts & ~par_nrfd & ~tx_valid, 1'b1);
		// Old bytes must be gone: the next byte read is the new one
		host_u.ser_send(8'h66);
		rd_take(e);
		chk_val(e, 9'h066);
		$display("clear test done");
		// Reset in mid-run with bytes held
		host_u.ser_send(8'h77);
		host_u.ser_send(8'h78);
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(1);
		chk_flag(rd_valid | par_nrfd | tx_valid, 1'b0);
		chk_flag(rts, 1'b1);
		host_u.ser_send(8'h12);
		rd_take(e);
		chk_val(e, 9'h012);
		$display("mid-run reset test done");
		print_verdict();
	end
endmodule

/* File: testbench/rib_host_model.sv */
// Host controller model: parallel bus talker and serial byte source
`timescale 1ns/1ps

module rib_host_model
	import rib_pkg::*;
(
	input wire logic ref_clk,
	input wire logic par_nrfd,
	output rib_in_t par_in,
	output rib_in_t ser_in
);
	//----------------------------------------
	// Idle lines
	//----------------------------------------
	initial begin
		par_in = '{1'b0, 1'b0, 8'hFF};
		ser_in = '{1'b0, 1'b0, 8'hFF};
	end

	//----------------------------------------
	// Transfers, called just after a rising edge
	//----------------------------------------
	// byte held until the hold-off is released
	task automatic par_send(input logic [7:0] d, input logic e);
		logic ok;
		par_in = '{1'b1, e, d};
		do begin
			ok = !par_nrfd;
			@(posedge ref_clk);
			#1;
		end while (!ok);
		// Released lines show the inverse so a stale byte cannot pass
		par_in = '{1'b0, ~e, ~d};
		// One idle edge so a following byte never re-raises valid in this step
		@(posedge ref_clk);
		#1;
	endtask

	// One-cycle pulse per byte, then a gap
	task automatic ser_send(input logic [7:0] d);
		ser_in = '{1'b1, 1'b0, d};
		@(posedge ref_clk);
		#1;
		ser_in = '{1'b0, 1'b1, ~d};
		@(posedge ref_clk);
		#1;
	endtask
endmodule
